// file: core/rpat_top.sv
// inbound address translator: four regions, register slave, output stage
// assumes inbound packets and the local bus run on ref_clk
//
// Notes on behaviour
// (R1) region one: below size, add offset
// (R2) region two: below size, add offset
// (R3) region three: below size, add offset
// (R4) size and offset fields hold bits 31..2
// (R5) low two bits read zero, writes ignored
// (R6) translated address drives local bus access
// (R7) region four works the same way
// (R8) first match wins; misses never forwarded
`timescale 1ns/10ps
module rpat_top (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    // register bus, write address
    input  wire logic [7:0]           s_axil_awaddr,
    input  wire logic                 s_axil_awvalid,
    output logic                      s_axil_awready,
    // register bus, write data
    input  wire logic [31:0]          s_axil_wdata,
    input  wire logic [3:0]           s_axil_wstrb,
    input  wire logic                 s_axil_wvalid,
    output logic                      s_axil_wready,
    // register bus, write response
    output logic [1:0]                s_axil_bresp,
    output logic                      s_axil_bvalid,
    input  wire logic                 s_axil_bready,
    // register bus, read
    input  wire logic [7:0]           s_axil_araddr,
    input  wire logic                 s_axil_arvalid,
    output logic                      s_axil_arready,
    output logic [31:0]               s_axil_rdata,
    output logic [1:0]                s_axil_rresp,
    output logic                      s_axil_rvalid,
    input  wire logic                 s_axil_rready,
    // inbound packets
    input  wire logic                 pkt_valid,
    output logic                      pkt_ready,
    input  wire rpat_pkg::rpat_acc_t  pkt_acc,
    // local configuration bus
    output logic                      cfg_valid,
    input  wire logic                 cfg_ready,
    output rpat_pkg::rpat_acc_t       cfg_acc,
    output logic                      pkt_miss
);
    import rpat_pkg::*;

    // region fields, bits 31..2 only
    logic [29:0] size_q [RPAT_REGION_N];
    logic [29:0] size_d [RPAT_REGION_N];
    logic [29:0] off_q  [RPAT_REGION_N];
    logic [29:0] off_d  [RPAT_REGION_N];

    // bus slave state
    logic        aw_held_q, aw_held_d;
    logic        w_held_q, w_held_d;
    logic [7:0]  awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0]  wstrb_q, wstrb_d;
    logic        bvalid_q, bvalid_d;
    logic [1:0]  bresp_q, bresp_d;
    logic        rvalid_q, rvalid_d;
    logic [1:0]  rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic        rd_region_q, rd_region_d;

    // translation state
    logic [15:0] miss_cnt_q, miss_cnt_d;
    logic [1:0]  last_q, last_d;
    logic        miss_q, miss_d;

    // translation datapath
    logic [RPAT_REGION_N-1:0] hit;
    logic [31:0]              xaddr [RPAT_REGION_N];
    logic [1:0]               sel;
    logic                     any_hit;
    logic                     fwd_ready;
    logic                     pkt_fire;
    logic                     write_go;
    rpat_acc_t                fwd_acc;
    rpat_dec_t                wr_dec;
    rpat_dec_t                rd_dec;
    logic [31:0]              wr_merge;

    // (R1) (R2) (R3) (R7) per-region compare and add
    for (genvar g = 0; g < RPAT_REGION_N; g++) begin : g_region
        rpat_region_match u_match (
            .pkt_addr     (pkt_acc.addr),
            .size_field   (size_q[g]),
            .offset_field (off_q[g]),
            .hit          (hit[g]),
            .xlate_addr   (xaddr[g])
        );
    end

    // (R8) lowest numbered matching region wins
    always_comb begin
        sel     = 2'h0;
        any_hit = |hit;
        for (int i = RPAT_REGION_N - 1; i >= 0; i--) begin
            if (hit[i]) begin
                sel = 2'(i);
            end
        end
    end

    // (R6) translated address replaces the packet address
    always_comb begin
        fwd_acc      = pkt_acc;
        fwd_acc.addr = xaddr[sel];
    end

    assign pkt_ready = fwd_ready;
    assign pkt_fire  = pkt_valid && fwd_ready;

    // (R8) only matching packets load the output stage
    rpat_fwd_stage u_fwd (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_valid  (pkt_valid && any_hit),
        .in_ready  (fwd_ready),
        .in_acc    (fwd_acc),
        .out_valid (cfg_valid),
        .out_ready (cfg_ready),
        .out_acc   (cfg_acc)
    );

    // miss count saturates, last region shows the latest hit
    always_comb begin
        miss_d     = pkt_fire && !any_hit;
        miss_cnt_d = miss_cnt_q;
        last_d     = last_q;
        if (miss_d && (miss_cnt_q != 16'hFFFF)) begin
            miss_cnt_d = miss_cnt_q + 16'h0001;
        end
        if (pkt_fire && any_hit) begin
            last_d = sel;
        end
    end

    // write channel: address and data in either order
    assign s_axil_awready = !aw_held_q;
    assign s_axil_wready  = !w_held_q;
    assign write_go       = aw_held_q && w_held_q && !bvalid_q;
    assign wr_dec         = rpat_decode(awaddr_q);

    always_comb begin
        wr_merge  = 32'h0000_0000;
        aw_held_d = aw_held_q;
        w_held_d  = w_held_q;
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        size_d    = size_q;
        off_d     = off_q;
        if (s_axil_awvalid && !aw_held_q) begin
            aw_held_d = 1'b1;
            awaddr_d  = s_axil_awaddr;
        end
        if (s_axil_wvalid && !w_held_q) begin
            w_held_d = 1'b1;
            wdata_d  = s_axil_wdata;
            wstrb_d  = s_axil_wstrb;
        end
        if (s_axil_bvalid && s_axil_bready) begin
            bvalid_d = 1'b0;
        end
        if (write_go) begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = (wr_dec.region || wr_dec.status) ? RPAT_RESP_OKAY
                                                         : RPAT_RESP_SLVERR;
            if (wr_dec.region) begin
                // (R4) (R5) merge bytes, keep only bits 31..2
                wr_merge = wr_dec.is_offset ? {off_q[wr_dec.idx], 2'h0}
                                            : {size_q[wr_dec.idx], 2'h0};
                for (int b = 0; b < 4; b++) begin
                    if (wstrb_q[b]) begin
                        wr_merge[8*b +: 8] = wdata_q[8*b +: 8];
                    end
                end
                if (wr_dec.is_offset) begin
                    off_d[wr_dec.idx] = wr_merge[31:RPAT_FIELD_LSB];
                end else begin
                    size_d[wr_dec.idx] = wr_merge[31:RPAT_FIELD_LSB];
                end
            end
        end
    end

    // read channel: one read under way at a time
    assign s_axil_arready = !rvalid_q;
    assign rd_dec         = rpat_decode(s_axil_araddr);

    always_comb begin
        rvalid_d    = rvalid_q;
        rresp_d     = rresp_q;
        rdata_d     = rdata_q;
        rd_region_d = rd_region_q;
        if (s_axil_rvalid && s_axil_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axil_arvalid && !rvalid_q) begin
            rvalid_d    = 1'b1;
            rresp_d     = RPAT_RESP_OKAY;
            rd_region_d = rd_dec.region;
            rdata_d     = 32'h0000_0000;
            if (rd_dec.region) begin
                // (R5) low bits always read zero
                rdata_d = rd_dec.is_offset ? {off_q[rd_dec.idx], 2'h0}
                                           : {size_q[rd_dec.idx], 2'h0};
            end else if (rd_dec.status) begin
                rdata_d[RPAT_STAT_MISS_LSB +: RPAT_STAT_MISS_W] = miss_cnt_q;
                rdata_d[RPAT_STAT_LAST_LSB +: 2]                = last_q;
                rdata_d[RPAT_STAT_BUSY_BIT]                     = cfg_valid;
            end else begin
                rresp_d = RPAT_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            aw_held_q   <= 1'b0;
            w_held_q    <= 1'b0;
            awaddr_q    <= 8'h00;
            wdata_q     <= 32'h0000_0000;
            wstrb_q     <= 4'h0;
            bvalid_q    <= 1'b0;
            bresp_q     <= RPAT_RESP_OKAY;
            rvalid_q    <= 1'b0;
            rresp_q     <= RPAT_RESP_OKAY;
            rdata_q     <= 32'h0000_0000;
            rd_region_q <= 1'b0;
            miss_cnt_q  <= RPAT_MISS_RESET;
            last_q      <= RPAT_LAST_RESET;
            miss_q      <= 1'b0;
            for (int i = 0; i < RPAT_REGION_N; i++) begin
                size_q[i] <= RPAT_FIELD_RESET;
                off_q[i]  <= RPAT_FIELD_RESET;
            end
        end else begin
            aw_held_q   <= aw_held_d;
            w_held_q    <= w_held_d;
            awaddr_q    <= awaddr_d;
            wdata_q     <= wdata_d;
            wstrb_q     <= wstrb_d;
            bvalid_q    <= bvalid_d;
            bresp_q     <= bresp_d;
            rvalid_q    <= rvalid_d;
            rresp_q     <= rresp_d;
            rdata_q     <= rdata_d;
            rd_region_q <= rd_region_d;
            miss_cnt_q  <= miss_cnt_d;
            last_q      <= last_d;
            miss_q      <= miss_d;
            size_q      <= size_d;
            off_q       <= off_d;
        end
    end

    assign s_axil_bvalid = bvalid_q;
    assign s_axil_bresp  = bresp_q;
    assign s_axil_rvalid = rvalid_q;
    assign s_axil_rresp  = rresp_q;
    assign s_axil_rdata  = rdata_q;
    assign pkt_miss      = miss_q;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_region1_xlate: assert property (pkt_fire && hit[0] |=> cfg_valid &&  // (R1)
        cfg_acc.addr == $past(pkt_acc.addr) + {$past(off_q[0]), 2'h0})
        else $error("region one translation wrong");

    a_region2_xlate: assert property (pkt_fire && !hit[0] && hit[1] |=>  // (R2)
        cfg_valid && cfg_acc.addr == $past(pkt_acc.addr) + {$past(off_q[1]), 2'h0})
        else $error("region two translation wrong");

    a_region3_xlate: assert property (pkt_fire && hit[2] && hit[1:0] == 2'h0  // (R3)
        |=> cfg_valid && cfg_acc.addr == $past(pkt_acc.addr) + {$past(off_q[2]), 2'h0})
        else $error("region three translation wrong");

    a_region4_xlate: assert property (pkt_fire && hit == 4'h8 |=>  // (R7)
        cfg_valid && cfg_acc.addr == $past(pkt_acc.addr) + {$past(off_q[3]), 2'h0})
        else $error("region four translation wrong");

    a_size_store: assert property (write_go && wr_dec.region && !wr_dec.is_offset  // (R4)
        && wr_dec.idx == 2'h0 && wstrb_q == 4'hF |=> size_q[0] == $past(wdata_q[31:2]))
        else $error("size field not stored from bits 31..2");

    a_low_bits_zero: assert property (s_axil_rvalid && rd_region_q |->  // (R5)
        s_axil_rdata[1:0] == 2'h0)
        else $error("region register low bits not zero");

    a_cfg_hold: assert property (cfg_valid && !cfg_ready |=>  // (R6)
        cfg_valid && $stable(cfg_acc))
        else $error("local bus access changed while stalled");

    a_miss_dropped: assert property (pkt_fire && hit == 4'h0 |=>  // (R8)
        pkt_miss && !cfg_valid)
        else $error("unmatched packet forwarded");

    c_region1_hit: cover property (pkt_fire && hit[0] ##1 cfg_valid && cfg_ready);
    c_miss: cover property (pkt_fire && !any_hit);
    c_stall: cover property ((cfg_valid && !cfg_ready) [*3] ##1 cfg_ready);
    c_overlap: cover property (pkt_fire && hit[0] && hit[1]);

endmodule

// file: core/rpat_pkg.sv
// shared constants and carriers of the inbound address translator
// assumes one 50 MHz clock and a synchronous active-high reset
package rpat_pkg;

    // data and address widths
    localparam int unsigned RPAT_DATA_W     = 32;
    localparam int unsigned RPAT_BUS_AW     = 8;
    localparam int unsigned RPAT_REGION_N   = 4;
    localparam int unsigned RPAT_FIELD_LSB  = 2;
    localparam int unsigned RPAT_FIELD_W    = RPAT_DATA_W - RPAT_FIELD_LSB;

    // register map: size at base + step*i, offset one word above it
    localparam logic [7:0]  RPAT_OFS_REGION_BASE = 8'h00;
    localparam logic [7:0]  RPAT_OFS_REGION_STEP = 8'h08;
    localparam logic [7:0]  RPAT_OFS_REGION_END  = 8'h20;
    localparam logic [7:0]  RPAT_OFS_STATUS      = 8'h20;

    // status register layout
    localparam int unsigned RPAT_STAT_MISS_LSB = 0;
    localparam int unsigned RPAT_STAT_MISS_W   = 16;
    localparam int unsigned RPAT_STAT_LAST_LSB = 16;
    localparam int unsigned RPAT_STAT_BUSY_BIT = 20;

    // values after reset
    localparam logic [29:0] RPAT_FIELD_RESET = 30'h0000_0000;
    localparam logic [15:0] RPAT_MISS_RESET  = 16'h0000;
    localparam logic [1:0]  RPAT_LAST_RESET  = 2'h0;

    // bus answers
    localparam logic [1:0]  RPAT_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RPAT_RESP_SLVERR = 2'h2;

    // one access: inbound packet or local configuration bus request
    typedef struct packed {
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } rpat_acc_t;

    // register decode result
    typedef struct packed {
        logic       region;
        logic       is_offset;
        logic [1:0] idx;
        logic       status;
    } rpat_dec_t;

    function automatic rpat_dec_t rpat_decode(input logic [7:0] a);
        rpat_dec_t d;
        logic [7:0] rel;
        d         = '0;
        rel       = a - RPAT_OFS_REGION_BASE;
        d.region  = (a >= RPAT_OFS_REGION_BASE) && (a < RPAT_OFS_REGION_END)
                    && (a[1:0] == 2'h0);
        d.idx       = rel[4:3];
        d.is_offset = rel[2];
        d.status    = (a == RPAT_OFS_STATUS);
        return d;
    endfunction

endpackage

// file: core/rpat_region_match.sv
// one translation region: compare and add
// assumes size and offset fields come from flip-flops on the same clock
`timescale 1ns/10ps
module rpat_region_match (
    // packet address
    input  wire logic [31:0] pkt_addr,
    // region fields, bits 31..2
    input  wire logic [29:0] size_field,
    input  wire logic [29:0] offset_field,
    // result
    output logic             hit,
    output logic [31:0]      xlate_addr
);
    import rpat_pkg::*;

    always_comb begin
        hit        = pkt_addr < {size_field, 2'h0};
        xlate_addr = pkt_addr + {offset_field, 2'h0};
    end

endmodule

// file: core/rpat_fwd_stage.sv
// one-entry output stage toward the local configuration bus
// assumes the local bus keeps valid/ready rules on the same clock
`timescale 1ns/10ps
module rpat_fwd_stage (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // load side
    input  wire logic              in_valid,
    output logic                   in_ready,
    input  wire rpat_pkg::rpat_acc_t in_acc,
    // bus side
    output logic                   out_valid,
    input  wire logic              out_ready,
    output rpat_pkg::rpat_acc_t    out_acc
);
    import rpat_pkg::*;

    logic      valid_q;
    logic      valid_d;
    rpat_acc_t acc_q;
    rpat_acc_t acc_d;

    always_comb begin
        in_ready = !valid_q || out_ready;
        valid_d  = valid_q;
        acc_d    = acc_q;
        if (valid_q && out_ready) begin
            valid_d = 1'b0;
        end
        if (in_valid && in_ready) begin
            valid_d = 1'b1;
            acc_d   = in_acc;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            valid_q <= 1'b0;
            acc_q   <= '0;
        end else begin
            valid_q <= valid_d;
            acc_q   <= acc_d;
        end
    end

    assign out_valid = valid_q;
    assign out_acc   = acc_q;

endmodule

// file: dv/rpat_pkt_src.sv
// remote link side: sends inbound packets toward the translator
// assumes send is called just after a rising edge of ref_clk
`timescale 1ns/10ps
module rpat_pkt_src (
    // clock
    input  wire logic           ref_clk,
    // packet channel
    output logic                pkt_valid,
    input  wire logic           pkt_ready,
    output rpat_pkg::rpat_acc_t pkt_acc
);
    import rpat_pkg::*;

    initial begin
        pkt_valid = 1'b0;
        pkt_acc   = '1;
    end

    // back to back: valid stays up between packets
    task automatic send(input rpat_acc_t q[$]);
        for (int i = 0; i < q.size(); i++) begin
            pkt_valid <= 1'b1;
            pkt_acc   <= q[i];
            do @(posedge ref_clk); while (pkt_ready !== 1'b1);
        end
        pkt_valid <= 1'b0;
        // released payload must not look valid
        pkt_acc   <= ~q[q.size() - 1];
    endtask
endmodule

// file: dv/test_rx_packet_address_translator.sv
// self-checking bench for the inbound address translator
// assumes rpat_top and rpat_pkt_src are compiled first
`timescale 1ns/10ps
module test_rx_packet_address_translator;
    import rpat_pkg::*;
    logic        ref_clk, rst, cfg_ready, pkt_valid, pkt_ready, cfg_valid, pkt_miss;
    logic [7:0]  s_axil_awaddr, s_axil_araddr;
    logic [31:0] s_axil_wdata, s_axil_rdata;
    logic [3:0]  s_axil_wstrb;
    logic [1:0]  s_axil_bresp, s_axil_rresp;
    logic        s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
    logic        s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready;
    logic        s_axil_rvalid, s_axil_rready;
    rpat_acc_t   pkt_acc, cfg_acc;
    rpat_acc_t   got[$];
    int          bad_count, n_checks, misses, cyc;

    rpat_top dut_u (
        .ref_clk, .rst, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready,
        .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready,
        .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_araddr,
        .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp,
        .s_axil_rvalid, .s_axil_rready, .pkt_valid, .pkt_ready, .pkt_acc,
        .cfg_valid, .cfg_ready, .cfg_acc, .pkt_miss
    );

    rpat_pkt_src src_u (.ref_clk, .pkt_valid, .pkt_ready, .pkt_acc);

    always #10 ref_clk = ~ref_clk;

    // local bus sink stalls one cycle in three
    always @(posedge ref_clk) begin
        cyc       <= cyc + 1;
        cfg_ready <= (cyc % 3) != 2;
        if (pkt_miss === 1'b1) misses <= misses + 1;
        if (cfg_valid === 1'b1 && cfg_ready === 1'b1) got.push_back(cfg_acc);
        if (cyc == 20000) begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic chk(input string n, input logic [64:0] e, input logic [64:0] s);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                       input logic [1:0] r);
        s_axil_awaddr  <= a;
        s_axil_wdata   <= d;
        s_axil_wstrb   <= s;
        s_axil_awvalid <= 1'b1;
        s_axil_wvalid  <= 1'b1;
        s_axil_bready  <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axil_awready === 1'b1) s_axil_awvalid <= 1'b0;
            if (s_axil_wready === 1'b1) s_axil_wvalid <= 1'b0;
        end while (s_axil_bvalid !== 1'b1);
        s_axil_bready <= 1'b0;
        chk("bresp", r, s_axil_bresp);
        // one idle edge keeps back-to-back drives apart
        @(posedge ref_clk);
    endtask

    task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        s_axil_araddr  <= a;
        s_axil_arvalid <= 1'b1;
        s_axil_rready  <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axil_arready === 1'b1) s_axil_arvalid <= 1'b0;
        end while (s_axil_rvalid !== 1'b1);
        s_axil_rready <= 1'b0;
        chk("rdata", d, s_axil_rdata);
        chk("rresp", r, s_axil_rresp);
        // one idle edge keeps back-to-back drives apart
        @(posedge ref_clk);
    endtask

    task automatic t_unprog;
        rpat_acc_t q[$];
        q.push_back('{1'b0, 32'h0, 32'h0});
        src_u.send(q);
        for (int k = 0; k < 20 && misses < 1; k++) @(posedge ref_clk);
        chk("unprog miss", 1, misses);
        chk("unprog fwd", 0, got.size());
        $display("test t_unprog done");
    endtask

    task automatic t_regs;
        for (int i = 0; i < 8; i++) begin
            axr(8'(4 * i), 32'h0, RPAT_RESP_OKAY);
            axw(8'(4 * i), 32'hFFFF_FFFF, 4'hF, RPAT_RESP_OKAY);
            axr(8'(4 * i), 32'hFFFF_FFFC, RPAT_RESP_OKAY);
            axw(8'(4 * i), 32'h0000_0003, 4'hF, RPAT_RESP_OKAY);
            axr(8'(4 * i), 32'h0, RPAT_RESP_OKAY);
        end
        axw(8'h0C, 32'h1234_5677, 4'h2, RPAT_RESP_OKAY);
        axr(8'h0C, 32'h0000_5600, RPAT_RESP_OKAY);
        axw(8'h40, 32'h5, 4'hF, RPAT_RESP_SLVERR);
        axr(8'h40, 32'h0, RPAT_RESP_SLVERR);
        axr(8'h06, 32'h0, RPAT_RESP_SLVERR);
        // status is read only: one miss so far, last region one
        axw(RPAT_OFS_STATUS, 32'hFFFF_FFFF, 4'hF, RPAT_RESP_OKAY);
        axr(RPAT_OFS_STATUS, 32'h0000_0001, RPAT_RESP_OKAY);
        $display("test t_regs done");
    endtask

    task automatic t_xlate;
        logic [31:0] rv [8] = '{32'h100, 32'h1000, 32'h200, 32'h2000_0000,
                                32'h400, 32'h4000, 32'h800, 32'hFFFF_FF00};
        logic [31:0] pa [8] = '{32'h0FF, 32'h100, 32'h1FC, 32'h800,
                                32'h200, 32'h3FF, 32'h400, 32'h7FF};
        logic [31:0] xa [8] = '{32'h10FF, 32'h2000_0100, 32'h2000_01FC, 32'h0,
                                32'h4200, 32'h43FF, 32'h0000_0300, 32'h0000_06FF};
        rpat_acc_t   q[$];
        rpat_acc_t   e;
        int          j;
        for (int i = 0; i < 8; i++) axw(8'(4 * i), rv[i], 4'hF, RPAT_RESP_OKAY);
        for (int i = 0; i < 8; i++) q.push_back('{i[0], pa[i], ~pa[i]});
        src_u.send(q);
        for (int k = 0; k < 60 && got.size() < 7; k++) @(posedge ref_clk);
        j = 0;
        for (int i = 0; i < 8; i++) begin
            if (i == 3) continue;
            e = '{i[0], xa[i], ~pa[i]};
            if (j < got.size()) chk("cfg_acc", e, got[j]);
            j++;
        end
        chk("hits", 7, got.size());
        chk("misses", 2, misses);
        // miss count 2, last hit in region four
        axr(RPAT_OFS_STATUS, 32'h0003_0002, RPAT_RESP_OKAY);
        $display("test t_xlate done");
    endtask

    task automatic t_live;
        rpat_acc_t q[$];
        got.delete();
        axw(8'h04, 32'h0000_8000, 4'hF, RPAT_RESP_OKAY);
        q.push_back('{1'b1, 32'h0000_0010, 32'h0});
        src_u.send(q);
        for (int k = 0; k < 20 && got.size() < 1; k++) @(posedge ref_clk);
        chk("live addr", 32'h0000_8010, got.size() ? got[0].addr : 32'h0);
        $display("test t_live done");
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        ref_clk        = 1'b0;
        rst            = 1'b1;
        cfg_ready      = 1'b1;
        s_axil_awaddr  = 8'h00;
        s_axil_araddr  = 8'h00;
        s_axil_wdata   = 32'h0;
        s_axil_wstrb   = 4'h0;
        s_axil_awvalid = 1'b0;
        s_axil_wvalid  = 1'b0;
        s_axil_bready  = 1'b0;
        s_axil_arvalid = 1'b0;
        s_axil_rready  = 1'b0;
        bad_count      = 0;
        n_checks       = 0;
        misses         = 0;
        cyc            = 0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        t_unprog();
        t_regs();
        t_xlate();
        t_live();
        end_of_test();
    end
endmodule
